// ---- src/fobr_ctrl.sv ----
// Option byte loader and CPU self-rewrite sequencer.
// Rules behind this block and the software that drives it
// [RULE_01] b0 low starts watchdog after reset.
// [RULE_02] b2 low unprotects; else b3 low protects.
// [RULE_03] b5:b4 pick voltage-detect-0 threshold.
// [RULE_04] One threshold feeds monitor and power-on reset.
// [RULE_05] b6 low enables low-voltage monitor reset.
// [RULE_06] b7 low enables count-source protection.
// [RULE_07] Option byte at 0FFFFh; erase reads FFh.
// [RULE_08] Software programs option byte once only.
// [RULE_09] Software targets only user ROM blocks.
// [RULE_10] Erase can suspend; reads and programs allowed.
// [RULE_11] Mode zero program runs from RAM.
// [RULE_12] Mode one refuses writes to control-program blocks.
// [RULE_13] Return to read array after operations.
// [RULE_14] Mode one holds CPU, ports on ROM; the code does not hold them for a ROM program issued in suspend.
// [RULE_15] CPU runs in mode zero, data flash.
// [RULE_16] Software polls ready and error flags.
// [RULE_17] Enable plus request bits suspend erase.
// [RULE_18] Enable plus interrupt bit: interrupt suspends.
// [RULE_19] Mode one software suspend only for data flash; the code suspends an erase of any block in either mode.
// [RULE_20] Protection refuses parallel rewrite; erase removes.
// [RULE_21] Status b7 low busy, high ready.
// [RULE_22] Option byte applied before CPU runs.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module fobr_ctrl #(
  parameter int unsigned PROG_CYC = fobr_pkg::PROG_CYC,
  parameter int unsigned ERASE_CYC = fobr_pkg::ERASE_CYC,
  parameter int MEM_DEPTH = 16,
  parameter int MEM_AW = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic mask_irq,
  input wire logic par_wr_req,
  output logic par_wr_refused,
  output fobr_pkg::fobr_cfg_t cfg,
  output logic cpu_run,
  output logic cpu_hold,
  output logic io_hold,
  output logic read_array
);

  // Elaboration checks: counters need at least two cycles to count down.
  if (PROG_CYC < 2 || ERASE_CYC < 2) begin : g_bad_cyc
    $error("fobr_ctrl: operation cycle counts must be at least 2.");
  end
  if (MEM_AW > 8) begin : g_bad_aw
    $error("fobr_ctrl: flash address register is only 8 bits wide.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.
  fobr_pkg::fobr_state_t state_q, state_d; // Sequencer state.
  fobr_pkg::fobr_cfg_t cfg_q, cfg_d; // Latched power-up configuration.
  logic run_q, run_d; // CPU released to fetch.
  logic [7:0] mode_q, mode_d; // Rewrite enable and mode select.
  logic sus_en_q, sus_en_d; // Suspend enable.
  logic sus_req_q, sus_req_d; // Suspend request, also set by hardware.
  logic sus_int_q, sus_int_d; // Interrupt suspend enable.
  logic [7:0] faddr_q, faddr_d; // Flash byte address inside the block.
  logic [7:0] fdata_q, fdata_d; // Data to program.
  logic [7:0] lock_q, lock_d; // Blocks holding the rewrite program.
  logic [2:0] blk_q, blk_d; // Block of the running operation.
  logic [2:0] pblk_q, pblk_d; // Block of a program issued in suspend.
  logic [31:0] pcnt_q, pcnt_d; // Program cycles left.
  logic [31:0] ecnt_q, ecnt_d; // Erase cycles left, kept over suspend.
  logic eer_q, eer_d; // Erase error flag.
  logic per_q, per_d; // Program error flag.
  logic [7:0] rdata_q, rdata_d; // Read data register.
  logic hold_q, hold_d; // CPU and port hold.
  logic refuse_q, refuse_d; // Parallel write refused.

  // Memory interface.
  logic mem_wr; // Program strobe into the option block.
  logic mem_erase; // Erase strobe for the option block.
  logic [7:0] mem_rdata; // Byte at the flash address register.
  logic [7:0] mem_top; // The option-select byte itself.

  // Decoded strobes.
  logic cmd_wr; // Software wrote the command register.
  logic [1:0] cmd_op; // Opcode of that write.
  logic [2:0] cmd_blk; // Target block of that write.
  logic ew1; // Erase-write mode one active.
  logic sus_hit; // Suspend condition this cycle.
  logic int_sus; // Interrupt-caused suspend.
  logic ready; // Flash is ready.

  ////////////////////////////////////////////////////////////////////////////
  // Flash array slice holding the option byte's block.
  fobr_opt_mem #(
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_mem (
    .sys_clk(sys_clk),
    .wr_en(mem_wr),
    .erase(mem_erase),
    .addr(faddr_q[MEM_AW-1:0]),
    .wdata(fdata_q),
    .rdata_q(mem_rdata),
    .top_q(mem_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and suspend conditions.
  assign cmd_wr = reg_wr && (reg_addr == fobr_pkg::REG_CMD)
                  && mode_q[fobr_pkg::MODE_EN] && run_q;
  assign cmd_op = reg_wdata[1:0];
  assign cmd_blk = reg_wdata[fobr_pkg::CMD_BLK_LSB +: 3];
  assign ew1 = mode_q[fobr_pkg::MODE_EW1];
  // The interrupt path only counts when its enable is set as well.
  assign int_sus = sus_en_q && sus_int_q && mask_irq; // [RULE_18]
  assign sus_hit = (sus_en_q && sus_req_q) || int_sus; // [RULE_17]
  // Busy also covers the option load after reset, while the array wakes up.
  assign ready = (state_q == fobr_pkg::FS_READY)
                 || (state_q == fobr_pkg::FS_SUSP); // [RULE_21]

  // Array strobes fire on the last cycle of an operation.
  assign mem_wr = (((state_q == fobr_pkg::FS_PROG)
                    && (blk_q == fobr_pkg::OPT_BLOCK))
                   || ((state_q == fobr_pkg::FS_SUSP_PROG)
                       && (pblk_q == fobr_pkg::OPT_BLOCK)))
                  && (pcnt_q == 32'h1);
  // Erasing the option block leaves the byte at FFh. [RULE_07]
  assign mem_erase = (state_q == fobr_pkg::FS_ERASE) && !sus_hit
                     && (ecnt_q == 32'h1)
                     && (blk_q == fobr_pkg::OPT_BLOCK); // [RULE_07]

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the sequencer and the configuration latch.
  always_comb begin
    state_d = state_q;
    cfg_d = cfg_q;
    run_d = run_q;
    blk_d = blk_q;
    pblk_d = pblk_q;
    pcnt_d = pcnt_q;
    ecnt_d = ecnt_q;
    eer_d = eer_q;
    per_d = per_q;
    unique case (state_q)
      // The memory's top register needs one edge before it is valid.
      fobr_pkg::FS_LOAD: begin
        state_d = fobr_pkg::FS_LATCH;
      end
      // Decode the option byte, then let the CPU fetch. [RULE_22]
      fobr_pkg::FS_LATCH: begin
        cfg_d.wdt_autostart = !mem_top[fobr_pkg::OPT_WDT]; // [RULE_01]
        cfg_d.rom_protect = mem_top[fobr_pkg::OPT_RCR]
                            && !mem_top[fobr_pkg::OPT_RCP]; // [RULE_02]
        cfg_d.vdet_lvm_level = mem_top[fobr_pkg::OPT_VDL +: 2]; // [RULE_03]
        cfg_d.vdet_por_level = mem_top[fobr_pkg::OPT_VDL +: 2]; // [RULE_04]
        cfg_d.lowvolt_reset_en = !mem_top[fobr_pkg::OPT_LVD]; // [RULE_05]
        cfg_d.csp_en = !mem_top[fobr_pkg::OPT_CSP]; // [RULE_06]
        run_d = 1'b1; // [RULE_22]
        state_d = fobr_pkg::FS_READY;
      end
      // Accept a new command; mode one refuses locked blocks outright.
      fobr_pkg::FS_READY: begin
        if (cmd_wr && (cmd_op == fobr_pkg::CMD_PROG)) begin
          per_d = 1'b0;
          eer_d = 1'b0;
          if (ew1 && lock_q[cmd_blk]) begin
            per_d = 1'b1; // [RULE_12]
          end else begin
            blk_d = cmd_blk;
            pcnt_d = PROG_CYC;
            state_d = fobr_pkg::FS_PROG;
          end
        end else if (cmd_wr && (cmd_op == fobr_pkg::CMD_ERASE)) begin
          per_d = 1'b0;
          eer_d = 1'b0;
          if (ew1 && lock_q[cmd_blk]) begin
            eer_d = 1'b1; // [RULE_12]
          end else begin
            blk_d = cmd_blk;
            ecnt_d = ERASE_CYC;
            state_d = fobr_pkg::FS_ERASE;
          end
        end
      end
      // Programming ends back in read array mode.
      fobr_pkg::FS_PROG: begin
        pcnt_d = pcnt_q - 32'h1;
        if (pcnt_q == 32'h1) begin
          state_d = fobr_pkg::FS_READY; // [RULE_13]
        end
      end
      // Erase may be halted; the remaining count is kept for resume.
      fobr_pkg::FS_ERASE: begin
        if (sus_hit) begin
          state_d = fobr_pkg::FS_SUSP; // [RULE_10] [RULE_13]
        end else if (ecnt_q == 32'h1) begin
          ecnt_d = 32'h0;
          state_d = fobr_pkg::FS_READY; // [RULE_13]
        end else begin
          ecnt_d = ecnt_q - 32'h1;
        end
      end
      // Suspended: reads go on, a program may run, erase is an error.
      fobr_pkg::FS_SUSP: begin
        if (cmd_wr && (cmd_op == fobr_pkg::CMD_PROG)) begin
          per_d = 1'b0;
          if ((ew1 && lock_q[cmd_blk]) || (cmd_blk == blk_q)) begin
            per_d = 1'b1; // [RULE_12]
          end else begin
            pblk_d = cmd_blk;
            pcnt_d = PROG_CYC;
            state_d = fobr_pkg::FS_SUSP_PROG; // [RULE_10]
          end
        end else if (cmd_wr && (cmd_op == fobr_pkg::CMD_ERASE)) begin
          eer_d = 1'b1;
        end else if (!sus_hit) begin
          state_d = fobr_pkg::FS_ERASE;
        end
      end
      // Program inside suspend returns to the suspended erase.
      fobr_pkg::FS_SUSP_PROG: begin
        pcnt_d = pcnt_q - 32'h1;
        if (pcnt_q == 32'h1) begin
          state_d = fobr_pkg::FS_SUSP; // [RULE_13]
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the software registers, hold and read data.
  always_comb begin
    mode_d = mode_q;
    sus_en_d = sus_en_q;
    sus_req_d = sus_req_q;
    sus_int_d = sus_int_q;
    faddr_d = faddr_q;
    fdata_d = fdata_q;
    lock_d = lock_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      unique case (reg_addr)
        fobr_pkg::REG_MODE: mode_d = reg_wdata;
        fobr_pkg::REG_SUSP: begin
          sus_en_d = reg_wdata[fobr_pkg::SUS_EN];
          sus_req_d = reg_wdata[fobr_pkg::SUS_REQ];
          sus_int_d = reg_wdata[fobr_pkg::SUS_INT];
        end
        fobr_pkg::REG_FADDR: faddr_d = reg_wdata;
        fobr_pkg::REG_FDATA: fdata_d = reg_wdata;
        fobr_pkg::REG_LOCK: lock_d = reg_wdata;
        default: ;
      endcase
    end
    // An interrupt suspend raises the request bit, so software resumes by
    // clearing it; the hardware set wins over a clear in the same cycle.
    if (int_sus && (state_q == fobr_pkg::FS_ERASE)) begin
      sus_req_d = 1'b1; // [RULE_18]
    end
    if (reg_rd) begin
      unique case (reg_addr)
        fobr_pkg::REG_STATUS: rdata_d = {ready,
          (state_q == fobr_pkg::FS_SUSP)
            || (state_q == fobr_pkg::FS_SUSP_PROG),
          eer_q, per_q, 4'h0}; // [RULE_21]
        fobr_pkg::REG_MODE: rdata_d = mode_q;
        fobr_pkg::REG_SUSP: rdata_d = {5'h00, sus_int_q, sus_req_q, sus_en_q};
        fobr_pkg::REG_FADDR: rdata_d = faddr_q;
        fobr_pkg::REG_FDATA: rdata_d = mem_rdata;
        fobr_pkg::REG_LOCK: rdata_d = lock_q;
        fobr_pkg::REG_OPT: rdata_d = mem_top; // [RULE_07]
        default: rdata_d = 8'h00;
      endcase
    end
    // Mode one stalls the CPU and ports only for program ROM work.
    hold_d = ew1 && (blk_d < fobr_pkg::DF_FIRST)
             && ((state_d == fobr_pkg::FS_PROG)
                 || (state_d == fobr_pkg::FS_ERASE)); // [RULE_14] [RULE_15]
    refuse_d = par_wr_req && cfg_q.rom_protect; // [RULE_20]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers. Configuration reads as all zeros until loaded.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= fobr_pkg::FS_LOAD;
      cfg_q <= '0;
      run_q <= 1'b0;
      mode_q <= fobr_pkg::MODE_RST;
      sus_en_q <= 1'b0;
      sus_req_q <= 1'b0;
      sus_int_q <= 1'b0;
      faddr_q <= 8'h00;
      fdata_q <= 8'h00;
      lock_q <= fobr_pkg::LOCK_RST;
      blk_q <= 3'h0;
      pblk_q <= 3'h0;
      pcnt_q <= 32'h0;
      ecnt_q <= 32'h0;
      eer_q <= 1'b0;
      per_q <= 1'b0;
      rdata_q <= 8'h00;
      hold_q <= 1'b0;
      refuse_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cfg_q <= cfg_d;
      run_q <= run_d;
      mode_q <= mode_d;
      sus_en_q <= sus_en_d;
      sus_req_q <= sus_req_d;
      sus_int_q <= sus_int_d;
      faddr_q <= faddr_d;
      fdata_q <= fdata_d;
      lock_q <= lock_d;
      blk_q <= blk_d;
      pblk_q <= pblk_d;
      pcnt_q <= pcnt_d;
      ecnt_q <= ecnt_d;
      eer_q <= eer_d;
      per_q <= per_d;
      rdata_q <= rdata_d;
      hold_q <= hold_d;
      refuse_q <= refuse_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign reg_rdata = rdata_q;
  assign cfg = cfg_q;
  assign cpu_run = run_q;
  assign cpu_hold = hold_q;
  assign io_hold = hold_q;
  assign read_array = ready; // [RULE_13]
  assign par_wr_refused = refuse_q;

endmodule

// ---- src/fobr_pkg.sv ----
// Shared constants, types and register map of the flash option/rewrite block.
package fobr_pkg;

  // Register addresses on the plain register port.
  localparam logic [15:0] REG_STATUS = 16'h01b2;
  localparam logic [15:0] REG_MODE = 16'h01b4;
  localparam logic [15:0] REG_SUSP = 16'h01b6;
  localparam logic [15:0] REG_CMD = 16'h01b8;
  localparam logic [15:0] REG_FADDR = 16'h01b9;
  localparam logic [15:0] REG_FDATA = 16'h01ba;
  localparam logic [15:0] REG_LOCK = 16'h01bb;
  localparam logic [15:0] REG_OPT = 16'hffff;

  // Option-select byte field positions.
  localparam int OPT_WDT = 0;
  localparam int OPT_RCR = 2;
  localparam int OPT_RCP = 3;
  localparam int OPT_VDL = 4;
  localparam int OPT_LVD = 6;
  localparam int OPT_CSP = 7;

  // Status register bit positions.
  localparam int ST_RDY = 7;
  localparam int ST_SUS = 6;
  localparam int ST_EER = 5;
  localparam int ST_PER = 4;

  // Mode register bits: rewrite enable and erase-write mode one select.
  localparam int MODE_EN = 1;
  localparam int MODE_EW1 = 2;

  // Suspend control register bits.
  localparam int SUS_EN = 0;
  localparam int SUS_REQ = 1;
  localparam int SUS_INT = 2;

  // Command register layout: opcode in the low bits, block above.
  localparam int CMD_BLK_LSB = 4;
  localparam logic [1:0] CMD_PROG = 2'h1;
  localparam logic [1:0] CMD_ERASE = 2'h2;

  // Blocks 0..3 are program ROM, 4..7 data flash.
  localparam logic [2:0] OPT_BLOCK = 3'h3;
  localparam logic [2:0] DF_FIRST = 3'h4;

  // Value of an erased flash byte.
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] LOCK_RST = 8'h00;

  // Operation times and their cycle counts at the system clock.
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 50;
  localparam int ERASE_TIME_US = 300000;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;

  // Power-up configuration decoded from the option-select byte.
  typedef struct packed {
    logic wdt_autostart;
    logic rom_protect;
    logic [1:0] vdet_lvm_level;
    logic [1:0] vdet_por_level;
    logic lowvolt_reset_en;
    logic csp_en;
  } fobr_cfg_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    FS_LOAD,
    FS_LATCH,
    FS_READY,
    FS_PROG,
    FS_ERASE,
    FS_SUSP,
    FS_SUSP_PROG
  } fobr_state_t;

endpackage

// ---- src/fobr_opt_mem.sv ----
// Flash array slice that holds the option-select byte's block.
`timescale 1ns/1ns
module fobr_opt_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic erase,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q,
  output logic [7:0] top_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage. A blank part ships fully erased.
  // The initialiser is not a process, so the always_ff below stays the
  // only writer of the array.
  logic [7:0] mem [DEPTH] = '{default: fobr_pkg::ERASED_BYTE};

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("fobr_opt_mem: DEPTH must equal 2**AW.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming can only clear bits, so a byte written twice without an
  // erase ends up as the AND of both values. Erase restores every byte.
  always_ff @(posedge sys_clk) begin
    if (erase) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= fobr_pkg::ERASED_BYTE;
      end
    end else if (wr_en) begin
      mem[addr] <= mem[addr] & wdata;
    end
    rdata_q <= mem[addr];
    top_q <= mem[DEPTH-1];
  end

endmodule

// ---- bench/fobr_ctrl_checker.sv ----
// Port-level assertions for the option byte loader and rewrite sequencer.
`timescale 1ns/1ns
module fobr_ctrl_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic par_wr_req,
  input wire logic par_wr_refused,
  input wire fobr_pkg::fobr_cfg_t cfg,
  input wire logic cpu_run,
  input wire logic cpu_hold,
  input wire logic io_hold,
  input wire logic read_array
);
  // All checks share the one system clock and its reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  // The option byte lands two edges after release and then stays put.
  a_load_before_run: assert property ($fell(rst) |->
    cfg == 8'h00 && !cpu_run && !read_array ##2 cpu_run && read_array)
    else $error("option byte not applied two cycles after reset");
  a_run_sticky: assert property (cpu_run |=> cpu_run)
    else $error("cpu run dropped without reset");
  a_cfg_frozen: assert property (
    cpu_run && $past(cpu_run) |-> $stable(cfg))
    else $error("configuration changed after it was applied");
  a_vdet_shared: assert property (
    cpu_run |-> cfg.vdet_lvm_level == cfg.vdet_por_level)
    else $error("monitor and power-on thresholds differ");

  ////////////////////////////////////////////////////////////////////////
  // Parallel writes are refused exactly while protection is active.
  a_par_refuse: assert property (
    par_wr_req && cfg.rom_protect |=> par_wr_refused)
    else $error("parallel write not refused under protection");
  a_par_allow: assert property (
    !(par_wr_req && cfg.rom_protect) |=> !par_wr_refused)
    else $error("parallel write refused without cause");

  ////////////////////////////////////////////////////////////////////////
  // Hold outputs move together and only rise while the array is busy.
  a_hold_pair: assert property (cpu_hold == io_hold)
    else $error("cpu hold and port hold disagree");
  a_hold_busy: assert property ($rose(cpu_hold) |-> !read_array)
    else $error("cpu held while array readable");
  a_ready_flag: assert property (
    reg_rd && reg_addr == fobr_pkg::REG_STATUS
    |=> reg_rdata[fobr_pkg::ST_RDY] == $past(read_array))
    else $error("ready flag disagrees with array state");
endmodule

bind fobr_ctrl fobr_ctrl_checker chk_u (
  .sys_clk(sys_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .par_wr_req(par_wr_req),
  .par_wr_refused(par_wr_refused),
  .cfg(cfg),
  .cpu_run(cpu_run),
  .cpu_hold(cpu_hold),
  .io_hold(io_hold),
  .read_array(read_array)
);

// ---- bench/fobr_cpu_model.sv ----
// Behavioural CPU that runs the rewrite program over the register port.
`timescale 1ns/1ns
module fobr_cpu_model (
  input wire logic sys_clk,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic mask_irq,
  output logic par_wr_req,
  input wire logic par_wr_refused
);
  // Everything idles low at time zero.
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mask_irq = 1'b0;
    par_wr_req = 1'b0;
  end

  // One-cycle write; released lines show the inverse so stale data shows.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // One-cycle read; data is taken in the following cycle only.
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 q = reg_rdata;
  endtask

  // Completion is learnt only by polling the ready flag, with a bound.
  task automatic wait_ready(output logic [7:0] st);
    st = 8'h00;
    for (int i = 0; i < 200 && st[7] !== 1'b1; i++) begin
      rd(fobr_pkg::REG_STATUS, st);
    end
  endtask

  // Interrupt line level, changed just after an edge.
  task automatic irq(input logic v);
    @(posedge sys_clk);
    mask_irq <= v;
  endtask

  // One-cycle parallel write attempt; the answer is the next cycle.
  task automatic par_try(output logic r);
    @(posedge sys_clk);
    par_wr_req <= 1'b1;
    @(posedge sys_clk);
    par_wr_req <= 1'b0;
    #1 r = par_wr_refused;
  endtask
endmodule

// ---- bench/tb_flash_option_byte_rewrite_ctrl.sv ----
// Self-checking bench for the option byte loader and rewrite sequencer.
`timescale 1ns/1ns
module tb_flash_option_byte_rewrite_ctrl;
  logic sys_clk;
  logic rst;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic mask_irq;
  logic par_wr_req;
  logic par_wr_refused;
  fobr_pkg::fobr_cfg_t cfg;
  logic cpu_run;
  logic cpu_hold;
  logic io_hold;
  logic read_array;
  int errors;
  int compares;
  logic [7:0] q;
  logic b;
  // Option bytes chosen to reach every threshold and both protect paths.
  logic [7:0] opts [5] = '{8'hff, 8'h52, 8'ha9, 8'h0e, 8'hf7};
  // Mode, command and expected hold for the CPU-state cases.
  logic [7:0] hmode [3] = '{8'h06, 8'h06, 8'h02};
  logic [7:0] hcmd [3] = '{8'h01, 8'h41, 8'h01};
  logic hexp [3] = '{1'b1, 1'b0, 1'b0};

  // Short counts keep each operation to a few cycles.
  fobr_ctrl #(.PROG_CYC(4), .ERASE_CYC(10)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mask_irq(mask_irq), .par_wr_req(par_wr_req),
    .par_wr_refused(par_wr_refused), .cfg(cfg), .cpu_run(cpu_run),
    .cpu_hold(cpu_hold), .io_hold(io_hold), .read_array(read_array));
  fobr_cpu_model cpu_u (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mask_irq(mask_irq), .par_wr_req(par_wr_req),
    .par_wr_refused(par_wr_refused));

  // 100 MHz system clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare helpers, verdict and reset.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Reset reloads the option byte, so it is replayed after each rewrite.
  task automatic do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // Decoded configuration expected from a stored option byte.
  function automatic logic [7:0] exp_cfg(input logic [7:0] v);
    exp_cfg = {~v[0], v[2] & ~v[3], v[5:4], v[5:4], ~v[6], ~v[7]};
  endfunction

  // Watchdog: the whole run needs well under ten thousand cycles.
  initial begin
    #100000;
    errors = errors + 1;
    conclude;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    do_reset;
    chk8(cfg, exp_cfg(8'hff));
    cpu_u.rd(fobr_pkg::REG_STATUS, q);
    chk8(q, 8'h80);
    // The option byte is not writable as a plain register.
    cpu_u.wr(fobr_pkg::REG_OPT, 8'h00);
    cpu_u.rd(fobr_pkg::REG_OPT, q);
    chk8(q, 8'hff);
    cpu_u.rd(16'h0000, q);
    chk8(q, 8'h00);
    // Erase, program once, reset, then check every decoded field.
    foreach (opts[i]) begin
      cpu_u.wr(fobr_pkg::REG_MODE, 8'h02);
      cpu_u.wr(fobr_pkg::REG_CMD, 8'h32);
      cpu_u.wait_ready(q);
      chk8(q, 8'h80);
      cpu_u.rd(fobr_pkg::REG_OPT, q);
      chk8(q, 8'hff);
      cpu_u.wr(fobr_pkg::REG_FADDR, 8'h0f);
      cpu_u.wr(fobr_pkg::REG_FDATA, opts[i]);
      cpu_u.wr(fobr_pkg::REG_CMD, 8'h31);
      cpu_u.wait_ready(q);
      cpu_u.rd(fobr_pkg::REG_OPT, q);
      chk8(q, opts[i]);
      do_reset;
      chk8(cfg, exp_cfg(opts[i]));
      chk1(cpu_run, 1'b1);
      cpu_u.par_try(b);
      chk1(b, opts[i][2] & ~opts[i][3]);
    end
    // Mode one refuses commands to blocks holding the rewrite program.
    cpu_u.wr(fobr_pkg::REG_MODE, 8'h06);
    cpu_u.wr(fobr_pkg::REG_LOCK, 8'h08);
    cpu_u.wr(fobr_pkg::REG_CMD, 8'h31);
    cpu_u.rd(fobr_pkg::REG_STATUS, q);
    chk8(q, 8'h90);
    cpu_u.wr(fobr_pkg::REG_CMD, 8'h32);
    cpu_u.rd(fobr_pkg::REG_STATUS, q);
    chk8(q, 8'ha0);
    cpu_u.rd(fobr_pkg::REG_OPT, q);
    chk8(q, 8'hf7);
    cpu_u.wr(fobr_pkg::REG_LOCK, 8'h00);
    // CPU hold only for program ROM work in mode one.
    for (int i = 0; i < 3; i++) begin
      cpu_u.wr(fobr_pkg::REG_MODE, hmode[i]);
      cpu_u.wr(fobr_pkg::REG_CMD, hcmd[i]);
      @(posedge sys_clk);
      #1;
      chk1(cpu_hold, hexp[i]);
      chk1(read_array, 1'b0);
      cpu_u.wait_ready(q);
      chk8(q, 8'h80);
      chk1(cpu_hold, 1'b0);
    end
    // Software suspend, a program inside it, then resume.
    cpu_u.wr(fobr_pkg::REG_MODE, 8'h02);
    cpu_u.wr(fobr_pkg::REG_CMD, 8'h42);
    cpu_u.wr(fobr_pkg::REG_SUSP, 8'h03);
    cpu_u.rd(fobr_pkg::REG_STATUS, q);
    chk8(q, 8'hc0);
    chk1(read_array, 1'b1);
    cpu_u.wr(fobr_pkg::REG_FADDR, 8'h00);
    cpu_u.wr(fobr_pkg::REG_FDATA, 8'h5a);
    cpu_u.wr(fobr_pkg::REG_CMD, 8'h31);
    cpu_u.wait_ready(q);
    chk8(q, 8'hc0);
    cpu_u.rd(fobr_pkg::REG_FDATA, q);
    chk8(q, 8'h5a);
    cpu_u.wr(fobr_pkg::REG_SUSP, 8'h01);
    cpu_u.wait_ready(q);
    chk8(q, 8'h80);
    // Interrupt-driven suspend; the request bit is cleared to resume.
    cpu_u.wr(fobr_pkg::REG_SUSP, 8'h05);
    cpu_u.wr(fobr_pkg::REG_CMD, 8'h42);
    cpu_u.irq(1'b1);
    cpu_u.rd(fobr_pkg::REG_STATUS, q);
    chk8(q, 8'hc0);
    cpu_u.irq(1'b0);
    // The interrupt has gone, but hardware left the request bit raised.
    cpu_u.rd(fobr_pkg::REG_SUSP, q);
    chk8(q, 8'h07);
    cpu_u.wr(fobr_pkg::REG_SUSP, 8'h01);
    cpu_u.wait_ready(q);
    chk8(q, 8'h80);
    conclude;
  end
endmodule
